//--- design/gpio_pin_cell_config.sv
// GPIO port configuration: drive modes, input buffer, routing, AHB-Lite regs
//
// Overview of operation
// - Each pin's input buffer is switched off by its bit in config-second.
// - Config bit 24 picks port threshold: 0 CMOS, 1 LVTTL.
// - Input buffer output goes to the peripheral chosen by route select.
// - Driver enable comes from the peripheral, or is always on for the firmware route.
// - Each pin y has a 3-bit drive mode at config bits 3y+2:3y.
// - Mode 2 strong low / weak high; mode 3 strong high / weak low.
// - Mode 4 strong low / released; mode 5 strong high / released.
// - Mode 6 drives strongly to the data value both ways.
// - Mode 7 pulls weakly high or low, never strong.
// - Reset mode 0 is analog: driver and input buffer both off.
// - Pin state reads zero for pins in analog mode.
// - Mode 1 keeps driver off and input buffer on.
// - Config bit 25 selects slow slew, reset fast.
`timescale 1ns/1ps
`default_nettype none
`include "gpio_pin_defines.svh"

module gpio_pin_cell_config
    import gpio_pin_pkg::*;
#(
    parameter int PINS = 8
) (
    // Clock, reset and freeze
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic clk_en,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    // Peripherals through the routing matrix
    input wire logic [PINS-1:0] periph_out,
    input wire logic [PINS-1:0] periph_oe,
    output logic [PINS-1:0] periph_in,
    output logic [PINS*`ROUTE_W-1:0] route_select,
    // Pads
    input wire logic [PINS-1:0] pad_in,
    output pad_ctrl_type [PINS-1:0] pad_ctrl,
    output logic threshold_lvttl,
    output logic slow_slew
);

    // Registers
    logic [31:0] drive_cfg_r;
    logic [PINS-1:0] input_buffer_off_r;
    logic [PINS*`ROUTE_W-1:0] route_r;
    logic [PINS-1:0] out_value_r;
    logic [PINS-1:0] pin_meta_r;
    logic [PINS-1:0] pin_sync_r;
    logic [PINS-1:0] buf_on;
    logic [PINS-1:0] pin_state;
    logic [PINS-1:0] periph_in_r;
    pad_ctrl_type [PINS-1:0] pad_ctrl_r;
    pad_ctrl_type [PINS-1:0] pad_ctrl_nxt;
    phase_type phase_r;
    phase_type phase_nxt;
    logic [5:0] addr_r;
    logic [31:0] hrdata_r;
    logic [31:0] rd_nxt;
    logic accept;

    // Read waits one cycle so a read right after a write sees new data
    assign hreadyout = clk_en && (phase_r != PH_RD_WAIT);
    assign hresp = 1'b0;
    assign hrdata = hrdata_r;
    assign accept = hsel && htrans[1] && hready && hreadyout;

    // Data phase sequencing
    always_comb begin
        phase_nxt = PH_IDLE;
        if (accept) begin
            phase_nxt = hwrite ? PH_WRITE : PH_RD_WAIT;
        end else if (phase_r == PH_RD_WAIT) begin
            phase_nxt = PH_RD_DONE;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            phase_r <= PH_IDLE;
            addr_r <= 6'h00;
        end else if (clk_en) begin
            phase_r <= phase_nxt;
            if (accept) begin
                addr_r <= {haddr[5:2], 2'b00};
            end
        end
    end

    // Register writes; unmapped offsets are ignored
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            drive_cfg_r <= `RST_DRIVE_CONFIG;
            input_buffer_off_r <= `RST_CONFIG_SECOND;
            route_r <= `RST_ROUTE_SELECT;
            out_value_r <= `RST_OUTPUT_VALUE;
        end else if (clk_en && phase_r == PH_WRITE) begin
            unique case (addr_r)
                `OFS_DRIVE_CONFIG: begin
                    drive_cfg_r <= hwdata & `CFG_USED_MASK;
                end
                `OFS_CONFIG_SECOND: begin
                    input_buffer_off_r <= hwdata[PINS-1:0];
                end
                `OFS_ROUTE_SELECT: begin
                    route_r <= hwdata[PINS*`ROUTE_W-1:0];
                end
                `OFS_OUTPUT_VALUE: begin
                    out_value_r <= hwdata[PINS-1:0];
                end
                default: begin
                end
            endcase
        end
    end

    // Read mux, taken while the read waits
    always_comb begin
        rd_nxt = 32'h0000_0000;
        unique case (addr_r)
            `OFS_DRIVE_CONFIG: rd_nxt = drive_cfg_r;
            `OFS_CONFIG_SECOND: rd_nxt[PINS-1:0] = input_buffer_off_r;
            `OFS_ROUTE_SELECT: rd_nxt[PINS*`ROUTE_W-1:0] = route_r;
            `OFS_OUTPUT_VALUE: rd_nxt[PINS-1:0] = out_value_r;
            `OFS_PIN_STATE: rd_nxt[PINS-1:0] = pin_state;
            default: rd_nxt = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata_r <= 32'h0000_0000;
        end else if (clk_en && phase_r == PH_RD_WAIT) begin
            hrdata_r <= rd_nxt;
        end
    end

    // Pad inputs cross in through two flops
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pin_meta_r <= '0;
            pin_sync_r <= '0;
        end else if (clk_en) begin
            pin_meta_r <= pad_in;
            pin_sync_r <= pin_meta_r;
        end
    end

    // Per-pin drive decode
    always_comb begin
        pad_ctrl_nxt = '0;
        for (int y = 0; y < PINS; y++) begin
            logic [`MODE_W-1:0] mode;
            logic [`ROUTE_W-1:0] sel;
            logic data;
            logic drv_en;
            mode = drive_cfg_r[`MODE_W*y +: `MODE_W];
            sel = route_r[`ROUTE_W*y +: `ROUTE_W];
            // Firmware route: data register drives; else the peripheral
            data = (sel == `ROUTE_FIRMWARE) ? out_value_r[y] : periph_out[y];
            drv_en = (sel == `ROUTE_FIRMWARE) ? 1'b1 : periph_oe[y];
            pad_ctrl_nxt[y].in_en = buf_on[y];
            if (drv_en) begin
                unique case (drive_mode_type'(mode))
                    MODE_ANALOG: begin
                    end
                    MODE_HIZ_DIGITAL: begin
                    end
                    MODE_PULL_UP: begin
                        pad_ctrl_nxt[y].weak_hi = data;
                        pad_ctrl_nxt[y].strong_lo = !data;
                    end
                    MODE_PULL_DOWN: begin
                        pad_ctrl_nxt[y].strong_hi = data;
                        pad_ctrl_nxt[y].weak_lo = !data;
                    end
                    MODE_OD_LOW: begin
                        pad_ctrl_nxt[y].strong_lo = !data;
                    end
                    MODE_OD_HIGH: begin
                        pad_ctrl_nxt[y].strong_hi = data;
                    end
                    MODE_STRONG: begin
                        pad_ctrl_nxt[y].strong_hi = data;
                        pad_ctrl_nxt[y].strong_lo = !data;
                    end
                    MODE_PULL_BOTH: begin
                        pad_ctrl_nxt[y].weak_hi = data;
                        pad_ctrl_nxt[y].weak_lo = !data;
                    end
                endcase
            end
        end
    end

    // Input buffer on unless analog mode or disabled by its bit
    generate
        for (genvar g = 0; g < PINS; g++) begin : g_buf
            assign buf_on[g] = (drive_cfg_r[`MODE_W*g +: `MODE_W]
                != MODE_ANALOG)
                && !input_buffer_off_r[g];
            assign pin_state[g] = buf_on[g] && pin_sync_r[g];
        end
    endgenerate

    // Pad outputs and routed inputs from flops, one cycle behind config
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pad_ctrl_r <= '0;
            periph_in_r <= '0;
        end else if (clk_en) begin
            pad_ctrl_r <= pad_ctrl_nxt;
            for (int y = 0; y < PINS; y++) begin
                periph_in_r[y] <= pin_state[y] &&
                    (route_r[`ROUTE_W*y +: `ROUTE_W] != `ROUTE_FIRMWARE);
            end
        end
    end

    assign pad_ctrl = pad_ctrl_r;
    assign periph_in = periph_in_r;
    assign route_select = route_r;
    assign threshold_lvttl = drive_cfg_r[`THRESH_BIT];
    assign slow_slew = drive_cfg_r[`SLOW_BIT];

    // Checks
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    chk_analog_no_drive: assert property (
        (clk_en && drive_cfg_r[2:0] == 3'h0) |=>
            !clk_en || (pad_ctrl_r[0] == '0))
        else $error("Analog pin 0 has a driver or buffer on");

    chk_hiz_digital_in: assert property (
        (clk_en && drive_cfg_r[2:0] == 3'h1 && !input_buffer_off_r[0]) |=>
            !clk_en || (pad_ctrl_r[0].in_en && !pad_ctrl_r[0].strong_hi
            && !pad_ctrl_r[0].strong_lo && !pad_ctrl_r[0].weak_hi))
        else $error("Digital high-Z pin 0 drives or has buffer off");

    chk_buffer_off_bit: assert property (
        (clk_en && input_buffer_off_r[0]) |=> !clk_en || !pad_ctrl_r[0].in_en)
        else $error("Input buffer on despite its off bit");

    chk_strong_follows: assert property (
        (clk_en && drive_cfg_r[2:0] == 3'h6 && route_r[3:0] == 4'h0) |=>
            !clk_en || (pad_ctrl_r[0].strong_hi == $past(out_value_r[0])
            && pad_ctrl_r[0].strong_lo == !$past(out_value_r[0])))
        else $error("Strong mode pin 0 does not follow data");

    chk_pull_up_mode: assert property (
        (clk_en && drive_cfg_r[2:0] == 3'h2 && route_r[3:0] == 4'h0) |=>
            !clk_en || (pad_ctrl_r[0].weak_hi == $past(out_value_r[0])
            && !pad_ctrl_r[0].strong_hi))
        else $error("Pull-up mode pin 0 wrong");

    chk_pull_both_weak: assert property (
        (clk_en && drive_cfg_r[2:0] == 3'h7) |=>
            !clk_en || (!pad_ctrl_r[0].strong_hi && !pad_ctrl_r[0].strong_lo))
        else $error("Pull-both mode pin 0 drives strongly");

    chk_od_low_release: assert property (
        (clk_en && drive_cfg_r[2:0] == 3'h4) |=>
            !clk_en || (!pad_ctrl_r[0].strong_hi && !pad_ctrl_r[0].weak_hi))
        else $error("Open-drain-low pin 0 drives high");

    chk_analog_reads_zero: assert property (
        (clk_en && phase_r == PH_RD_WAIT && addr_r == `OFS_PIN_STATE
            && drive_cfg_r[2:0] == 3'h0) |=> (hrdata_r[0] == 1'b0))
        else $error("Analog pin 0 reads nonzero state");

    chk_cfg_readback: assert property (
        (clk_en && phase_r == PH_RD_WAIT && addr_r == `OFS_DRIVE_CONFIG) |=>
            (hrdata_r[31:26] == 6'h00 && hrdata_r == $past(drive_cfg_r)))
        else $error("Config readback wrong");

    chk_read_wait_once: assert property (
        (phase_r == PH_RD_WAIT && clk_en) |=> hreadyout || !clk_en)
        else $error("Read data phase longer than two cycles");

    cov_cfg_write: cover property (clk_en && phase_r == PH_WRITE
        && addr_r == `OFS_DRIVE_CONFIG);
    cov_pin_state_read: cover property (clk_en && phase_r == PH_RD_DONE
        && addr_r == `OFS_PIN_STATE && hrdata_r != 32'h0000_0000);
    cov_periph_drive: cover property (clk_en && route_r[3:0] != 4'h0
        && periph_oe[0] && pad_ctrl_r[0].strong_hi);
    cov_slow_slew: cover property (slow_slew && threshold_lvttl);

endmodule

`default_nettype wire

//--- design/gpio_pin_defines.svh
// Register offsets, field positions and reset values of the GPIO port block
`ifndef GPIO_PIN_DEFINES_SVH
`define GPIO_PIN_DEFINES_SVH

// Register byte offsets, one aligned word each
`define OFS_DRIVE_CONFIG 6'h00
`define OFS_CONFIG_SECOND 6'h04
`define OFS_ROUTE_SELECT 6'h08
`define OFS_OUTPUT_VALUE 6'h0C
`define OFS_PIN_STATE 6'h10

// Field positions
`define MODE_W 3
`define ROUTE_W 4
`define THRESH_BIT 24
`define SLOW_BIT 25
`define CFG_USED_MASK 32'h03FF_FFFF

// Reset values
`define RST_DRIVE_CONFIG 32'h0000_0000
`define RST_CONFIG_SECOND 8'h00
`define RST_ROUTE_SELECT 32'h0000_0000
`define RST_OUTPUT_VALUE 8'h00

// Route code that hands the pin to firmware
`define ROUTE_FIRMWARE 4'h0

`endif

//--- design/gpio_pin_pkg.sv
// Types shared by the GPIO port configuration block
package gpio_pin_pkg;

    // Per-pin drive mode codes
    typedef enum logic [2:0] {
        MODE_ANALOG = 3'b000,
        MODE_HIZ_DIGITAL = 3'b001,
        MODE_PULL_UP = 3'b010,
        MODE_PULL_DOWN = 3'b011,
        MODE_OD_LOW = 3'b100,
        MODE_OD_HIGH = 3'b101,
        MODE_STRONG = 3'b110,
        MODE_PULL_BOTH = 3'b111
    } drive_mode_type;

    // Bus data-phase tracking
    typedef enum logic [1:0] {
        PH_IDLE = 2'b00,
        PH_WRITE = 2'b01,
        PH_RD_WAIT = 2'b10,
        PH_RD_DONE = 2'b11
    } phase_type;

    // Pad controls for one pin
    typedef struct packed {
        logic strong_hi;
        logic strong_lo;
        logic weak_hi;
        logic weak_lo;
        logic in_en;
    } pad_ctrl_type;

endpackage

//--- verif/gpio_pin_cell_config_test.sv
// Self-checking bench for the GPIO port configuration block
`timescale 1ns/1ps
`default_nettype none
`include "gpio_pin_defines.svh"

module gpio_pin_cell_config_test
    import gpio_pin_pkg::*;
;
    logic hclk, hresetn, clk_en, hsel, hwrite, hreadyout, hresp;
    logic [31:0] haddr, hwdata, hrdata, route_select, q;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [7:0] periph_out, periph_oe, periph_in, pad_in, ext_en, ext_val;
    logic threshold_lvttl, slow_slew;
    pad_ctrl_type [7:0] pad_ctrl;
    int error_cnt, checks, cyc;

    gpio_pin_cell_config #(.PINS(8)) i_gpio_pin_cell_config (
        .hclk(hclk), .hresetn(hresetn), .clk_en(clk_en), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
        .hresp(hresp), .hrdata(hrdata), .periph_out(periph_out),
        .periph_oe(periph_oe), .periph_in(periph_in),
        .route_select(route_select), .pad_in(pad_in), .pad_ctrl(pad_ctrl),
        .threshold_lvttl(threshold_lvttl), .slow_slew(slow_slew));

    gpio_pin_far_side i_gpio_pin_far_side (.hclk(hclk), .pad_ctrl(pad_ctrl),
        .ext_en(ext_en), .ext_val(ext_val), .pad_in(pad_in));

    // Clock at 40 MHz
    initial begin
        hclk = 1'b0;
        forever #12.5 hclk = ~hclk;
    end

    task automatic conclude;
        $display("Comparisons %0d, mismatches %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask

    // Hang guard: the whole sequence needs about a hundred cycles
    always @(posedge hclk) begin
        cyc++;
        if (cyc == 3000) begin
            error_cnt++;
            $display("ERROR at %0t: timeout", $time);
            conclude;
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // One AHB-Lite single word transfer; no wait count assumed
    task automatic bus(input logic wr, input logic [5:0] a,
                       input logic [31:0] d);
        hsel <= 1'b1;
        htrans <= 2'b10;
        hwrite <= wr;
        haddr <= {26'h0, a};
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= wr ? d : 32'h0;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        q = hrdata;
    endtask

    task automatic wr(input logic [5:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask

    task automatic rd_chk(input logic [5:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0);
        chk(q, exp);
    endtask

    // Expected pad controls {strong_hi, strong_lo, weak_hi, weak_lo, in_en}
    function automatic logic [4:0] exp_pad(input logic [2:0] m,
        input logic d, input logic drv, input logic ib);
        logic [3:0] p;
        case (m)
            3'h2: p = d ? 4'h2 : 4'h4;
            3'h3: p = d ? 4'h8 : 4'h1;
            3'h4: p = d ? 4'h0 : 4'h4;
            3'h5: p = d ? 4'h8 : 4'h0;
            3'h6: p = d ? 4'h8 : 4'h4;
            3'h7: p = d ? 4'h2 : 4'h1;
            default: p = 4'h0;
        endcase
        return {drv ? p : 4'h0, ib && m != 3'h0};
    endfunction

    task automatic check_pads(input logic [23:0] cfg, input logic [7:0] d,
        input logic [7:0] drv, input logic [7:0] ib);
        for (int y = 0; y < 8; y++) begin
            chk({27'h0, pad_ctrl[y]},
                {27'h0, exp_pad(cfg[3*y +: 3], d[y], drv[y], ib[y])});
        end
    endtask

    // Main sequence: each pin y gets mode y so one pass covers all modes
    initial begin
        hresetn = 1'b0;
        clk_en = 1'b1;
        hsel = 1'b0;
        hwrite = 1'b0;
        htrans = 2'b00;
        hsize = 3'h2;
        haddr = 32'h0;
        hwdata = 32'h0;
        periph_out = 8'h00;
        periph_oe = 8'h00;
        ext_en = 8'h00;
        ext_val = 8'h00;
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        check_pads(24'h0, 8'h00, 8'hFF, 8'hFF);
        chk({29'h0, threshold_lvttl, slow_slew, hresp}, 32'h0);
        rd_chk(`OFS_DRIVE_CONFIG, 32'h0);
        wr(`OFS_DRIVE_CONFIG, 32'hFFFF_FFFF);
        rd_chk(`OFS_DRIVE_CONFIG, 32'h03FF_FFFF);
        chk({30'h0, threshold_lvttl, slow_slew}, 32'h3);
        wr(`OFS_DRIVE_CONFIG, 32'h0100_0000);
        @(posedge hclk);
        chk({30'h0, threshold_lvttl, slow_slew}, 32'h2);
        wr(`OFS_OUTPUT_VALUE, 32'h0000_00AA);
        wr(`OFS_DRIVE_CONFIG, 32'h00FA_C688);
        repeat (2) @(posedge hclk);
        check_pads(24'hFAC688, 8'hAA, 8'hFF, 8'hFF);
        wr(`OFS_OUTPUT_VALUE, 32'h0000_0055);
        repeat (2) @(posedge hclk);
        check_pads(24'hFAC688, 8'h55, 8'hFF, 8'hFF);
        // Pin 0 walks modes 1 to 4 so the pin 0 assertions on those modes get exercised
        for (int m = 1; m < 5; m++) begin
            wr(`OFS_DRIVE_CONFIG, {29'h0, m[2:0]});
            repeat (2) @(posedge hclk);
            check_pads({21'h0, m[2:0]}, 8'h55, 8'hFF, 8'hFF);
        end
        wr(`OFS_DRIVE_CONFIG, 32'h00FA_C688);
        // Outside drives every pin high; with all-ones data no pad drives strong low
        wr(`OFS_OUTPUT_VALUE, 32'h0000_00FF);
        ext_en <= 8'hFF;
        ext_val <= 8'hFF;
        wr(`OFS_CONFIG_SECOND, 32'h0000_000F);
        repeat (3) @(posedge hclk);
        check_pads(24'hFAC688, 8'hFF, 8'hFF, 8'hF0);
        rd_chk(`OFS_PIN_STATE, 32'h0000_00F0);
        wr(`OFS_CONFIG_SECOND, 32'h0000_0000);
        repeat (3) @(posedge hclk);
        rd_chk(`OFS_PIN_STATE, 32'h0000_00FE);
        // Pin 0 and pin 1 go to peripherals; pin 1 driver left disabled
        wr(`OFS_OUTPUT_VALUE, 32'h0000_0000);
        wr(`OFS_DRIVE_CONFIG, 32'h00DB_6DB6);
        ext_en <= 8'h02;
        ext_val <= 8'h02;
        periph_out <= 8'h03;
        periph_oe <= 8'h01;
        wr(`OFS_ROUTE_SELECT, 32'h0000_0031);
        // Pad drive, two sync flops and the input register: four edges,
        // so look one edge later than the fourth launches periph_in
        repeat (5) @(posedge hclk);
        chk(route_select, 32'h0000_0031);
        check_pads(24'hDB6DB6, 8'h01, 8'hFD, 8'hFF);
        chk({24'h0, periph_in}, 32'h0000_0003);
        wr(6'h14, 32'hFFFF_FFFF);
        rd_chk(6'h14, 32'h0);
        rd_chk(`OFS_ROUTE_SELECT, 32'h0000_0031);
        // Freeze stalls the bus until the clock enable returns
        clk_en <= 1'b0;
        repeat (3) @(posedge hclk);
        chk({31'h0, hreadyout}, 32'h0);
        clk_en <= 1'b1;
        wr(`OFS_DRIVE_CONFIG, 32'h0200_0000);
        rd_chk(`OFS_DRIVE_CONFIG, 32'h0200_0000);
        wr(`OFS_DRIVE_CONFIG, 32'h0000_0000);
        repeat (2) @(posedge hclk);
        check_pads(24'h0, 8'h00, 8'hFF, 8'hFF);
        rd_chk(`OFS_PIN_STATE, 32'h0000_0000);
        conclude;
    end
endmodule
`default_nettype wire

//--- verif/gpio_pin_far_side.sv
// Pad model: resolves the block's pad drive against an outside driver
`timescale 1ns/1ps
`default_nettype none

module gpio_pin_far_side
    import gpio_pin_pkg::*;
(
    // Clock
    input wire logic hclk,
    // Pad controls and outside driver
    input wire pad_ctrl_type [7:0] pad_ctrl,
    input wire logic [7:0] ext_en,
    input wire logic [7:0] ext_val,
    // Levels seen by the block
    output logic [7:0] pad_in
);
    logic tog;

    // A pin nobody drives wanders, so it toggles instead of holding a level
    initial tog = 1'b0;
    always @(posedge hclk) tog <= ~tog;

    // Outside strong driver beats pad pulls; strong beats weak in the pad
    always_comb begin
        for (int y = 0; y < 8; y++) begin
            if (ext_en[y]) pad_in[y] = ext_val[y];
            else if (pad_ctrl[y].strong_hi) pad_in[y] = 1'b1;
            else if (pad_ctrl[y].strong_lo) pad_in[y] = 1'b0;
            else if (pad_ctrl[y].weak_hi) pad_in[y] = 1'b1;
            else if (pad_ctrl[y].weak_lo) pad_in[y] = 1'b0;
            else pad_in[y] = tog;
        end
    end
endmodule
`default_nettype wire
